// >>> bench/adr_antenna_model.sv
`timescale 1ns/100ps

module adr_antenna_model (
   // Driver side
   input wire        pin,
   input wire [5:0]  pside,
   input wire [5:0]  nside,
   // Network load
   output logic [5:0] load_drive
);
   // High pin is pulled by the p-side, low pin by the n-side
   assign load_drive = pin ? pside : nside;
endmodule

// >>> bench/adr_props.sv
`timescale 1ns/100ps
`include "adr_defs.vh"

module adr_props (
   // Clock and reset
   input wire                     clk,
   input wire                     rstn,
   // Bus handshake
   input wire                     read,
   input wire                     write,
   input wire                     waitrequest,
   // Drivers
   input wire                     antenna_drive_pin_a,
   input wire [`ADR_STR_W-1:0]    pside_conductance_a,
   input wire [`ADR_STR_W-1:0]    nside_conductance_a,
   input wire                     antenna_drive_pin_b,
   input wire [`ADR_STR_W-1:0]    pside_conductance_b,
   input wire [`ADR_STR_W-1:0]    nside_conductance_b,
   input wire                     carrier,
   input wire                     carrier_inverted
);
   logic [1:0] live;

   // Counts edges past the internal two-flop release
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         live <= 2'h0;
      else if (live != 2'h3)
         live <= live + 2'h1;
   end

   default clocking dc @(posedge clk); endclocking
   default disable iff (live != 2'h3);

   sequence bus_first;
      (read || write) && waitrequest;
   endsequence
   sequence pair_a;
      (pside_conductance_a != 0 && nside_conductance_a != 0) [*2] ##0 !carrier;
   endsequence
   sequence pair_b;
      (pside_conductance_b != 0 && nside_conductance_b != 0) [*2] ##0 !carrier;
   endsequence
   property static_level(p, n, pin);
      (p != 0 && n == 0 |-> pin) and (p == 0 && n != 0 |-> !pin);
   endproperty

   AST_CARRIER_TOGGLE: assert property (carrier != $past(carrier))
      else $error("carrier did not toggle");
   AST_CARRIER_COMPL: assert property (carrier_inverted == !carrier)
      else $error("carrier complement wrong");
   AST_STATIC_A: assert property (static_level(
      pside_conductance_a, nside_conductance_a, antenna_drive_pin_a))
      else $error("pin a level disagrees with active side");
   AST_STATIC_B: assert property (static_level(
      pside_conductance_b, nside_conductance_b, antenna_drive_pin_b))
      else $error("pin b level disagrees with active side");
   AST_CARRIER_A: assert property (pair_a |-> $stable(antenna_drive_pin_a ^ carrier))
      else $error("pin a lost carrier phase");
   AST_CARRIER_B: assert property (pair_b |-> $stable(antenna_drive_pin_b ^ carrier))
      else $error("pin b lost carrier phase");
   AST_SAMPLE_TICK: assert property ($changed({pside_conductance_a, nside_conductance_a,
      pside_conductance_b, nside_conductance_b}) |-> carrier)
      else $error("strength changed off a carrier tick");
   AST_ONE_WAIT: assert property (bus_first |=> !waitrequest)
      else $error("bus answer not after one wait cycle");
   AST_WAIT_START: assert property ($rose(read || write) |-> waitrequest)
      else $error("no wait in first request cycle");
endmodule

bind adr_top adr_props adr_props_inst (
   .clk(clk), .rstn(rstn), .read(read), .write(write), .waitrequest(waitrequest),
   .antenna_drive_pin_a(antenna_drive_pin_a), .pside_conductance_a(pside_conductance_a),
   .nside_conductance_a(nside_conductance_a), .antenna_drive_pin_b(antenna_drive_pin_b),
   .pside_conductance_b(pside_conductance_b), .nside_conductance_b(nside_conductance_b),
   .carrier(carrier), .carrier_inverted(carrier_inverted)
);

// >>> bench/tb_top.sv
`timescale 1ns/100ps
`include "adr_defs.vh"

module tb_top;
   typedef struct {string n; logic [31:0] v; bit cf;} adr_note_t;
   logic        clk, rstn, read, write, envelope, probe;
   logic [4:0]  address;
   logic [31:0] writedata, readdata;
   logic [3:0]  byteenable;
   logic        waitrequest, pin_a, pin_b, carrier, carrier_inverted;
   logic [5:0]  ps_a, ns_a, ps_b, ns_b, load_a;
   logic [5:0]  str [6];
   adr_note_t   notes [$];
   int          fails, checked, cycles;

   adr_top adr_top_inst (.clk(clk), .rstn(rstn), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .envelope(envelope), .antenna_drive_pin_a(pin_a),
      .pside_conductance_a(ps_a), .nside_conductance_a(ns_a), .antenna_drive_pin_b(pin_b),
      .pside_conductance_b(ps_b), .nside_conductance_b(ns_b), .carrier(carrier),
      .carrier_inverted(carrier_inverted));
   adr_antenna_model adr_antenna_model_inst (.pin(pin_a), .pside(ps_a), .nside(ns_a),
      .load_drive(load_a));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", n, exp, seen);
      end
   endtask

   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         report_and_stop();
      end
   end

   // Takes the oldest note whenever a read completes, and the two oldest when a probe is raised
   always @(posedge clk) begin
      adr_note_t   e;
      logic [31:0] x;
      if (read && !waitrequest) begin
         e = notes.pop_front();
         check(e.n, readdata, e.v);
      end
      if (probe) begin
         e = notes.pop_front();
         x = e.v ^ {19'h0, e.cf & carrier, 12'h0};
         check(e.n, 32'({pin_a, ps_a, ns_a}), x);
         check("load a", 32'(load_a), 32'(x[12] ? x[11:6] : x[5:0]));
         e = notes.pop_front();
         x = e.v ^ {19'h0, e.cf & carrier, 12'h0};
         check(e.n, 32'({pin_b, ps_b, ns_b}), x);
      end
   end

   task automatic bus(bit wr, logic [4:0] a, logic [31:0] d, logic [3:0] be, logic [31:0] exp);
      @(posedge clk);
      if (!wr)
         notes.push_back('{$sformatf("read %h", a), exp, 1'b0});
      address <= a;
      writedata <= d;
      byteenable <= be;
      read <= !wr;
      write <= wr;
      @(posedge clk iff !waitrequest);
      read <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic wr_rd(logic [4:0] a, logic [31:0] d);
      bus(1'b1, a, d, 4'hf, 32'h0);
      bus(1'b0, a, 32'h0, 4'h0, d);
   endtask

   // Expected pin and strengths of one driver; cf marks a carrier-following pin
   task automatic note_drv(logic [7:0] c, logic env, bit b);
      logic        en, inv_on, inv_off, e, single;
      logic [12:0] v;
      bit          cf;
      en = b ? c[1] : c[0];
      inv_on = b ? c[5] : c[3];
      inv_off = b ? c[6] : c[4];
      e = env | (b & c[7]);
      single = c[0] ^ c[1];
      cf = 1'b0;
      if (!en && inv_off)
         v = {1'b1, e ? str[0] : str[1], 6'h0};
      else if (!en)
         v = {7'h0, single ? (e ? str[2] : str[3]) : (e ? str[4] : str[5])};
      else if (c[2] && !e)
         v = {7'h0, str[3]};
      else begin
         cf = 1'b1;
         v = {inv_on, e ? str[0] : str[1], e ? str[2] : str[3]};
      end
      notes.push_back('{b ? "drive b" : "drive a", 32'(v), cf});
   endtask

   task automatic set_str();
      for (int k = 0; k < 6; k++)
         str[k] = 6'h1 + 6'($urandom_range(62));
      wr_rd(`ADR_OFS_PSIDE, {18'h0, str[1], 2'h0, str[0]});
      wr_rd(`ADR_OFS_NSIDE_ON, {18'h0, str[3], 2'h0, str[2]});
      wr_rd(`ADR_OFS_NSIDE_OFF, {18'h0, str[5], 2'h0, str[4]});
   endtask

   initial begin
      logic [7:0] c;
      rstn = 1'b0;
      read = 1'b0;
      write = 1'b0;
      envelope = 1'b0;
      probe = 1'b0;
      address = 5'h0;
      writedata = 32'h0;
      byteenable = 4'h0;
      void'($urandom(32'h68a8be75));
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      bus(1'b0, `ADR_OFS_CTRL, 32'h0, 4'h0, 32'h0);
      for (int k = 1; k < 4; k++)
         bus(1'b0, 5'(4 * k), 32'h0, 4'h0, 32'h00003f3f);
      bus(1'b1, 5'h14, 32'hffffffff, 4'hf, 32'h0);
      bus(1'b0, 5'h14, 32'h0, 4'h0, 32'h0);
      bus(1'b1, `ADR_OFS_PSIDE, 32'h00000101, 4'h1, 32'h0);
      bus(1'b0, `ADR_OFS_PSIDE, 32'h0, 4'h0, 32'h00003f01);
      for (int i = 0; i < 512; i++) begin
         if (i % 64 == 0)
            set_str();
         c = i[7:0];
         bus(1'b1, `ADR_OFS_CTRL, 32'(c), 4'hf, 32'h0);
         @(posedge clk) envelope <= i[8];
         repeat (5) @(posedge clk);
         note_drv(c, i[8], 1'b0);
         note_drv(c, i[8], 1'b1);
         @(posedge clk) probe <= 1'b1;
         @(posedge clk) probe <= 1'b0;
      end
      repeat (2) @(posedge clk);
      report_and_stop();
   end
endmodule

// >>> inc/adr_defs.vh
`ifndef ADR_DEFS_VH
`define ADR_DEFS_VH

// Register byte addresses
`define ADR_OFS_CTRL       5'h00
`define ADR_OFS_PSIDE      5'h04
`define ADR_OFS_NSIDE_ON   5'h08
`define ADR_OFS_NSIDE_OFF  5'h0c
`define ADR_OFS_STATUS     5'h10

// Control register fields
`define ADR_CTRL_EN_A      0
`define ADR_CTRL_EN_B      1
`define ADR_CTRL_FORCE     2
`define ADR_CTRL_INV_ON_A  3
`define ADR_CTRL_INV_OFF_A 4
`define ADR_CTRL_INV_ON_B  5
`define ADR_CTRL_INV_OFF_B 6
`define ADR_CTRL_CW_B      7
`define ADR_CTRL_BITS      8

// Strength registers: continuous wave in [5:0], modulation in [13:8]
`define ADR_STR_W          6
`define ADR_STR_CW_LSB     0
`define ADR_STR_MOD_LSB    8

// Reset values
`define ADR_RST_CTRL       8'h00
`define ADR_RST_STR        6'h3f

// Drive mode encoding shown in status
`define ADR_MODE_STATIC    2'h0
`define ADR_MODE_CARRIER   2'h1
`define ADR_MODE_FORCED    2'h2

// Bus answer latency in wait cycles
`define ADR_WAIT_CYCLES    1

`endif

// >>> rtl/adr_drv_sel.v
`timescale 1ns/100ps
`include "adr_defs.vh"

module adr_drv_sel (
   // Clock and reset
   input  wire                     clk,
   input  wire                     rst_n,
   // Carrier timing
   input  wire                     carrier_tick,
   input  wire                     next_carrier,
   // Control
   input  wire                     carrier_enable,
   input  wire                     full_depth_ask_force,
   input  wire                     invert_when_carrier_on,
   input  wire                     invert_when_carrier_off,
   input  wire                     cw_force,
   input  wire                     use_field_on,
   input  wire                     envelope,
   // Strength settings
   input  wire [`ADR_STR_W-1:0]    pside_continuous_wave_strength,
   input  wire [`ADR_STR_W-1:0]    pside_modulation_strength,
   input  wire [`ADR_STR_W-1:0]    nside_field_on_continuous_strength,
   input  wire [`ADR_STR_W-1:0]    nside_field_on_modulation_strength,
   input  wire [`ADR_STR_W-1:0]    nside_field_off_continuous_strength,
   input  wire [`ADR_STR_W-1:0]    nside_field_off_modulation_strength,
   // Driver outputs
   output reg                      drive_pin,
   output reg  [`ADR_STR_W-1:0]    pside_conductance,
   output reg  [`ADR_STR_W-1:0]    nside_conductance,
   output reg  [1:0]               drive_mode
);

   // Controls held for one whole carrier period
   reg                   h_en;
   reg                   h_force;
   reg                   h_inv_on;
   reg                   h_inv_off;
   reg                   h_cw;
   reg                   h_field_on;
   reg                   h_env;

   reg  [1:0]            next_mode;
   reg                   next_pin;
   reg  [`ADR_STR_W-1:0] next_p;
   reg  [`ADR_STR_W-1:0] next_n;
   wire                  wave_sel;

   assign wave_sel = h_env | h_cw;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         h_en       <= 1'b0;
         h_force    <= 1'b0;
         h_inv_on   <= 1'b0;
         h_inv_off  <= 1'b0;
         h_cw       <= 1'b0;
         h_field_on <= 1'b0;
         h_env      <= 1'b0;
      end else if (carrier_tick) begin
         // Sampled only at the carrier low edge, so no runt pulses
         h_en       <= carrier_enable;
         h_force    <= full_depth_ask_force;
         h_inv_on   <= invert_when_carrier_on;
         h_inv_off  <= invert_when_carrier_off;
         h_cw       <= cw_force;
         h_field_on <= use_field_on;
         h_env      <= envelope;
      end
   end

   always @* begin
      next_mode = `ADR_MODE_STATIC;
      next_pin  = 1'b0;
      next_p    = {`ADR_STR_W{1'b0}};
      next_n    = {`ADR_STR_W{1'b0}};
      if (!h_en) begin
         next_pin = h_inv_off;
         if (h_inv_off) begin
            next_p = wave_sel ? pside_continuous_wave_strength
                              : pside_modulation_strength;
         end else if (h_field_on) begin
            next_n = wave_sel ? nside_field_on_continuous_strength
                              : nside_field_on_modulation_strength;
         end else begin
            next_n = wave_sel ? nside_field_off_continuous_strength
                              : nside_field_off_modulation_strength;
         end
      end else if (h_force && !wave_sel) begin
         next_mode = `ADR_MODE_FORCED;
         next_pin  = 1'b0;
         next_n    = nside_field_on_modulation_strength;
      end else begin
         next_mode = `ADR_MODE_CARRIER;
         next_pin  = next_carrier ^ h_inv_on;
         next_p    = wave_sel ? pside_continuous_wave_strength
                              : pside_modulation_strength;
         next_n    = wave_sel ? nside_field_on_continuous_strength
                              : nside_field_on_modulation_strength;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         drive_pin         <= 1'b0;
         pside_conductance <= {`ADR_STR_W{1'b0}};
         nside_conductance <= {`ADR_STR_W{1'b0}};
         drive_mode        <= `ADR_MODE_STATIC;
      end else begin
         drive_pin <= next_pin;
         // Strength writes reach the pins only as the carrier rises
         if (!carrier_tick) begin
            pside_conductance <= next_p;
            nside_conductance <= next_n;
            drive_mode        <= next_mode;
         end
      end
   end

endmodule

// >>> rtl/adr_top.v
`timescale 1ns/100ps
`include "adr_defs.vh"

module adr_top (
   // Clock and reset
   input  wire                     clk,
   input  wire                     rstn,
   // Avalon-MM slave
   input  wire [4:0]               address,
   input  wire                     read,
   input  wire                     write,
   input  wire [31:0]              writedata,
   input  wire [3:0]               byteenable,
   output reg  [31:0]              readdata,
   output wire                     waitrequest,
   // Modulation envelope
   input  wire                     envelope,
   // Driver pin A
   output wire                     antenna_drive_pin_a,
   output wire [`ADR_STR_W-1:0]    pside_conductance_a,
   output wire [`ADR_STR_W-1:0]    nside_conductance_a,
   // Driver pin B
   output wire                     antenna_drive_pin_b,
   output wire [`ADR_STR_W-1:0]    pside_conductance_b,
   output wire [`ADR_STR_W-1:0]    nside_conductance_b,
   // Carrier
   output wire                     carrier,
   output wire                     carrier_inverted
);

   // Reset synchroniser
   reg                        rst_meta;
   reg                        rst_n;

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // Carrier divider
   reg                        carrier_q;
   wire                       next_carrier;
   wire                       carrier_tick;

   assign next_carrier     = ~carrier_q;
   assign carrier          = carrier_q;
   assign carrier_inverted = ~carrier_q;
   assign carrier_tick     = carrier_q;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         carrier_q <= 1'b0;
      end else begin
         carrier_q <= next_carrier;
      end
   end

   // Register file
   reg  [`ADR_CTRL_BITS-1:0]  ctrl;
   reg  [`ADR_STR_W-1:0]      pside_continuous_wave_strength;
   reg  [`ADR_STR_W-1:0]      pside_modulation_strength;
   reg  [`ADR_STR_W-1:0]      nside_field_on_continuous_strength;
   reg  [`ADR_STR_W-1:0]      nside_field_on_modulation_strength;
   reg  [`ADR_STR_W-1:0]      nside_field_off_continuous_strength;
   reg  [`ADR_STR_W-1:0]      nside_field_off_modulation_strength;

   wire                       carrier_enable_a;
   wire                       carrier_enable_b;
   wire                       full_depth_ask_force;
   wire                       invert_when_carrier_on_a;
   wire                       invert_when_carrier_off_a;
   wire                       invert_when_carrier_on_b;
   wire                       invert_when_carrier_off_b;
   wire                       cw_force_b;
   wire                       single_driver;

   assign carrier_enable_a          = ctrl[`ADR_CTRL_EN_A];
   assign carrier_enable_b          = ctrl[`ADR_CTRL_EN_B];
   assign full_depth_ask_force      = ctrl[`ADR_CTRL_FORCE];
   assign invert_when_carrier_on_a  = ctrl[`ADR_CTRL_INV_ON_A];
   assign invert_when_carrier_off_a = ctrl[`ADR_CTRL_INV_OFF_A];
   assign invert_when_carrier_on_b  = ctrl[`ADR_CTRL_INV_ON_B];
   assign invert_when_carrier_off_b = ctrl[`ADR_CTRL_INV_OFF_B];
   assign cw_force_b                = ctrl[`ADR_CTRL_CW_B];
   assign single_driver             = carrier_enable_a ^ carrier_enable_b;

   // Bus handshake: one wait cycle, then answer
   reg                        ack;
   wire                       req;
   wire                       wr_take;

   assign req         = read | write;
   assign waitrequest = req & ~ack;
   assign wr_take     = write & ack;

   function [31:0] merge;
      input [31:0] old_word;
      input [31:0] new_word;
      input [3:0]  lanes;
      integer      i;
      begin
         merge = old_word;
         for (i = 0; i < 4; i = i + 1) begin
            if (lanes[i]) begin
               merge[i*8 +: 8] = new_word[i*8 +: 8];
            end
         end
      end
   endfunction

   function [31:0] pack_pair;
      input [`ADR_STR_W-1:0] cw_val;
      input [`ADR_STR_W-1:0] mod_val;
      begin
         pack_pair = 32'h0000_0000;
         pack_pair[`ADR_STR_CW_LSB +: `ADR_STR_W]  = cw_val;
         pack_pair[`ADR_STR_MOD_LSB +: `ADR_STR_W] = mod_val;
      end
   endfunction

   wire [31:0] ctrl_word;
   wire [31:0] ctrl_new;
   wire [31:0] pside_word;
   wire [31:0] pside_new;
   wire [31:0] non_word;
   wire [31:0] non_new;
   wire [31:0] noff_word;
   wire [31:0] noff_new;
   wire [31:0] status_word;

   assign ctrl_word  = {24'h00_0000, ctrl};
   assign ctrl_new   = merge(ctrl_word, writedata, byteenable);
   assign pside_word = pack_pair(pside_continuous_wave_strength, pside_modulation_strength);
   assign pside_new  = merge(pside_word, writedata, byteenable);
   assign non_word   = pack_pair(nside_field_on_continuous_strength,
                                 nside_field_on_modulation_strength);
   assign non_new    = merge(non_word, writedata, byteenable);
   assign noff_word  = pack_pair(nside_field_off_continuous_strength,
                                 nside_field_off_modulation_strength);
   assign noff_new   = merge(noff_word, writedata, byteenable);

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ack <= 1'b0;
      end else begin
         ack <= req & ~ack;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl                                <= `ADR_RST_CTRL;
         pside_continuous_wave_strength      <= `ADR_RST_STR;
         pside_modulation_strength           <= `ADR_RST_STR;
         nside_field_on_continuous_strength  <= `ADR_RST_STR;
         nside_field_on_modulation_strength  <= `ADR_RST_STR;
         nside_field_off_continuous_strength <= `ADR_RST_STR;
         nside_field_off_modulation_strength <= `ADR_RST_STR;
      end else if (wr_take) begin
         case ({address[4:2], 2'b00})
            `ADR_OFS_CTRL: begin
               ctrl <= ctrl_new[`ADR_CTRL_BITS-1:0];
            end
            `ADR_OFS_PSIDE: begin
               pside_continuous_wave_strength <= pside_new[`ADR_STR_CW_LSB +: `ADR_STR_W];
               pside_modulation_strength      <= pside_new[`ADR_STR_MOD_LSB +: `ADR_STR_W];
            end
            `ADR_OFS_NSIDE_ON: begin
               nside_field_on_continuous_strength <= non_new[`ADR_STR_CW_LSB +: `ADR_STR_W];
               nside_field_on_modulation_strength <= non_new[`ADR_STR_MOD_LSB +: `ADR_STR_W];
            end
            `ADR_OFS_NSIDE_OFF: begin
               nside_field_off_continuous_strength <= noff_new[`ADR_STR_CW_LSB +: `ADR_STR_W];
               nside_field_off_modulation_strength <= noff_new[`ADR_STR_MOD_LSB +: `ADR_STR_W];
            end
            default: begin
               ctrl <= ctrl;
            end
         endcase
      end
   end

   // Read data captured in the wait cycle
   reg  [31:0] next_readdata;

   always @* begin
      case ({address[4:2], 2'b00})
         `ADR_OFS_CTRL:      next_readdata = ctrl_word;
         `ADR_OFS_PSIDE:     next_readdata = pside_word;
         `ADR_OFS_NSIDE_ON:  next_readdata = non_word;
         `ADR_OFS_NSIDE_OFF: next_readdata = noff_word;
         `ADR_OFS_STATUS:    next_readdata = status_word;
         default:            next_readdata = 32'h0000_0000;
      endcase
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         readdata <= 32'h0000_0000;
      end else if (read && !ack) begin
         readdata <= next_readdata;
      end
   end

   // Driver selectors
   wire [1:0] mode_a;
   wire [1:0] mode_b;

   adr_drv_sel u_sel_a (
      .clk                                 (clk),
      .rst_n                               (rst_n),
      .carrier_tick                        (carrier_tick),
      .next_carrier                        (next_carrier),
      .carrier_enable                      (carrier_enable_a),
      .full_depth_ask_force                (full_depth_ask_force),
      .invert_when_carrier_on              (invert_when_carrier_on_a),
      .invert_when_carrier_off             (invert_when_carrier_off_a),
      .cw_force                            (1'b0),
      .use_field_on                        (single_driver),
      .envelope                            (envelope),
      .pside_continuous_wave_strength      (pside_continuous_wave_strength),
      .pside_modulation_strength           (pside_modulation_strength),
      .nside_field_on_continuous_strength  (nside_field_on_continuous_strength),
      .nside_field_on_modulation_strength  (nside_field_on_modulation_strength),
      .nside_field_off_continuous_strength (nside_field_off_continuous_strength),
      .nside_field_off_modulation_strength (nside_field_off_modulation_strength),
      .drive_pin                           (antenna_drive_pin_a),
      .pside_conductance                   (pside_conductance_a),
      .nside_conductance                   (nside_conductance_a),
      .drive_mode                          (mode_a)
   );

   adr_drv_sel u_sel_b (
      .clk                                 (clk),
      .rst_n                               (rst_n),
      .carrier_tick                        (carrier_tick),
      .next_carrier                        (next_carrier),
      .carrier_enable                      (carrier_enable_b),
      .full_depth_ask_force                (full_depth_ask_force),
      .invert_when_carrier_on              (invert_when_carrier_on_b),
      .invert_when_carrier_off             (invert_when_carrier_off_b),
      .cw_force                            (cw_force_b),
      .use_field_on                        (single_driver),
      .envelope                            (envelope),
      .pside_continuous_wave_strength      (pside_continuous_wave_strength),
      .pside_modulation_strength           (pside_modulation_strength),
      .nside_field_on_continuous_strength  (nside_field_on_continuous_strength),
      .nside_field_on_modulation_strength  (nside_field_on_modulation_strength),
      .nside_field_off_continuous_strength (nside_field_off_continuous_strength),
      .nside_field_off_modulation_strength (nside_field_off_modulation_strength),
      .drive_pin                           (antenna_drive_pin_b),
      .pside_conductance                   (pside_conductance_b),
      .nside_conductance                   (nside_conductance_b),
      .drive_mode                          (mode_b)
   );

   // Status: live pin levels, modes, carrier and envelope
   assign status_word = {23'h00_0000, single_driver, envelope, carrier_q,
                         mode_b, mode_a, antenna_drive_pin_b, antenna_drive_pin_a};

endmodule
